/* dv/regfile_model.sv */
`timescale 1ns/1ns
`default_nettype none
module regfile_model (
  input  wire logic        clk_in,    // Quarter clock
  input  wire logic [11:0] addr_in,   // Register address
  input  wire logic        rd_in,     // Read strobe
  input  wire logic        wr_in,     // Write strobe
  input  wire logic [7:0]  wdata_in,  // Write data
  output logic [7:0]       rdata_out  // Read data
);
  logic [7:0] mem_q [4096];
  logic [7:0] last_q = 8'h00;

  // Outside a read the bus shows junk, so a late sample is caught
  always_comb begin
    rdata_out = rd_in ? mem_q[addr_in] : ~last_q;
  end

  always @(posedge clk_in) begin
    if (wr_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    last_q <= rdata_out;
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pair_move_pkg::*;
  logic        ref_clk_in    = 1'b0;
  logic        resetn_in     = 1'b0;
  logic        start_in      = 1'b0;
  logic [15:0] instr_word_in = 16'h0000;
  logic [11:0] sp_in         = 12'h000;
  logic [7:0]  mem_rdata;
  logic [11:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [1:0]  quarter;
  logic        busy;
  logic        done;
  logic        skipped;
  int          miscompares     = 0;
  int          samples_checked = 0;
  int          rd_n;
  int          wr_n;

  always #20 ref_clk_in = ~ref_clk_in;

  indexed_pair_move u_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .start_in(start_in),
    .instr_word_in(instr_word_in), .sp_in(sp_in),
    .mem_rdata_in(mem_rdata), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
    .mem_wr_out(mem_wr), .mem_wdata_out(mem_wdata), .quarter_out(quarter),
    .busy_out(busy), .done_out(done), .skipped_out(skipped));

  regfile_model u_mem (
    .clk_in(ref_clk_in), .addr_in(mem_addr), .rd_in(mem_rd),
    .wr_in(mem_wr), .wdata_in(mem_wdata), .rdata_out(mem_rdata));

  task automatic print_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("MISMATCH %s expected handshake seen timeout", what);
  endtask

  // Start is raised early; the block ignores it until an idle Q1
  task automatic run_move(input logic [11:0] sp, input logic [6:0] zs,
                          input logic [6:0] zd);
    int n;
    rd_n = 0;
    wr_n = 0;
    @(posedge ref_clk_in);
    sp_in         <= sp;
    start_in      <= 1'b1;
    instr_word_in <= {FIRST_OP, zs};
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (busy !== 1'b1 && n < 40);
    if (busy !== 1'b1) begin
      hang("busy");
      return;
    end
    @(posedge ref_clk_in);
    start_in      <= 1'b0;
    instr_word_in <= {9'h1E0, zd};
    // Slots count falling edges from the Q2 of the first cycle
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
      if (mem_rd === 1'b1) begin
        rd_n++;
        cmp("read quarter", {6'h00, Q4}, {6'h00, quarter});
        cmp("read slot", 8'h02, n[7:0]);
      end
      if (mem_wr === 1'b1) begin
        wr_n++;
        cmp("write quarter", {6'h00, Q4}, {6'h00, quarter});
        cmp("write slot", 8'h06, n[7:0]);
      end
    end
    if (done !== 1'b1) begin
      hang("done");
      return;
    end
    cmp("done slot", 8'h07, n[7:0]);
  endtask

  task automatic t_basic;
    u_mem.mem_q[12'h085] = 8'h33;
    u_mem.mem_q[12'h086] = 8'h11;
    run_move(12'h080, 7'h05, 7'h06);
    cmp("dest 086", 8'h33, u_mem.mem_q[12'h086]);
    cmp("source 085", 8'h33, u_mem.mem_q[12'h085]);
    cmp("write count", 8'h01, wr_n[7:0]);
    cmp("skipped", 8'h00, {7'h00, skipped});
    run_move(12'h080, 7'h06, 7'h7F);
    cmp("dest 0FF", 8'h33, u_mem.mem_q[12'h0FF]);
    $display("test basic done");
  endtask

  task automatic t_wrap;
    u_mem.mem_q[12'h06F] = 8'hA5;
    run_move(12'hFF0, 7'h7F, 7'h10);
    cmp("dest 000", 8'hA5, u_mem.mem_q[12'h000]);
    $display("test wrap done");
  endtask

  task automatic t_ind_src;
    u_mem.mem_q[12'hFEB] = 8'h77;
    u_mem.mem_q[12'hFE1] = 8'h5A;
    run_move(12'hFE0, 7'h0B, 7'h01);
    cmp("dest FE1", 8'h00, u_mem.mem_q[12'hFE1]);
    cmp("read count", 8'h00, rd_n[7:0]);
    $display("test indirect source done");
  endtask

  task automatic t_ind_dst;
    u_mem.mem_q[12'hF80] = 8'h42;
    u_mem.mem_q[12'hFE5] = 8'h99;
    run_move(12'hF80, 7'h00, 7'h65);
    cmp("dest FE5", 8'h99, u_mem.mem_q[12'hFE5]);
    cmp("write count", 8'h00, wr_n[7:0]);
    cmp("skipped", 8'h01, {7'h00, skipped});
    $display("test indirect dest done");
  endtask

  task automatic t_protect;
    logic [11:0] a;
    for (int i = 0; i < PROT_CNT; i++) begin
      a = PROT_ADDR[i];
      u_mem.mem_q[a] = 8'hC3;
      run_move(12'hF80, 7'h00, 7'(a - 12'hF80));
      cmp("protected", 8'hC3, u_mem.mem_q[a]);
      cmp("write count", 8'h00, wr_n[7:0]);
      cmp("skipped", 8'h01, {7'h00, skipped});
    end
    $display("test protected done");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    t_basic();
    t_wrap();
    t_ind_src();
    t_ind_dst();
    t_protect();
    print_verdict();
  end
endmodule
`default_nettype wire

/* logic/addr_class.sv */
`timescale 1ns/1ns
`default_nettype none
module addr_class
  import pair_move_pkg::*;
(
  input  wire logic [11:0] addr_in,       // Computed data address
  output logic             indirect_out,  // Selects an indirect register
  output logic             protect_out    // Selects a protected register
);
  logic [IND_CHANS-1:0] ind_hit;
  logic [PROT_CNT-1:0]  prot_hit;
  logic [11:0]          ind_dist [IND_CHANS];

  // Each channel owns a window of five addresses counting down
  for (genvar c = 0; c < IND_CHANS; c++) begin : g_ind
    assign ind_dist[c] = IND_TOP[c] - addr_in;
    assign ind_hit[c]  = (addr_in <= IND_TOP[c]) && (ind_dist[c] < IND_SPAN_W);
  end

  for (genvar p = 0; p < PROT_CNT; p++) begin : g_prot
    assign prot_hit[p] = (addr_in == PROT_ADDR[p]);
  end

  assign indirect_out = |ind_hit;
  assign protect_out  = |prot_hit;
endmodule
`default_nettype wire

/* logic/indexed_pair_move.sv */
// Summary of operation
// RULE1: Addresses are stack pointer plus 7-bit offsets
// RULE2: Copy source value to destination, nothing else
// RULE3: Addresses wrap within the 4096-byte space
// RULE4: Never write program counter or stack bytes
// RULE5: Indirect source reads as zero, no access
// RULE6: Indirect destination makes the move a no-op
// RULE7: Two cycles: read Q4 first, write Q4 second
`timescale 1ns/1ns
`default_nettype none
module indexed_pair_move
  import pair_move_pkg::*;
(
  input  wire logic        ref_clk_in,     // Quarter clock, 25 MHz
  input  wire logic        resetn_in,      // Async reset, active low
  input  wire logic        start_in,       // First word present in Q1
  input  wire logic [15:0] instr_word_in,  // Current instruction word
  input  wire logic [11:0] sp_in,          // software_stack_pointer value
  input  wire logic [7:0]  mem_rdata_in,   // Register file read data
  output logic [11:0]      mem_addr_out,   // Register file address
  output logic             mem_rd_out,     // Read strobe, Q4 of cycle 1
  output logic             mem_wr_out,     // Write strobe, Q4 of cycle 2
  output logic [7:0]       mem_wdata_out,  // Write data
  output logic [1:0]       quarter_out,    // Current quarter phase
  output logic             busy_out,       // Move in progress
  output logic             done_out,       // One-quarter pulse at end
  output logic             skipped_out     // Last move wrote nothing
);
  logic        rst_meta_q;
  logic        rst_sync_q;
  logic        rstn;
  logic [1:0]  q_q;
  move_state_e st_q;
  logic [6:0]  zs_q;
  logic [6:0]  zd_q;
  logic [11:0] src_addr_q;
  logic [11:0] dst_addr_q;
  logic [7:0]  data_q;
  logic [11:0] addr_q;
  logic        rd_q;
  logic        wr_q;
  logic [7:0]  wdata_q;
  logic        done_q;
  logic        skip_q;
  logic        accept;
  logic        src_ind;
  logic        src_prot;
  logic        dst_ind;
  logic        dst_prot;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rstn = rst_sync_q;

  // One ref clock per quarter, four quarters per instruction cycle
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      q_q <= Q1;
    end else begin
      q_q <= q_q + QTR_STEP;
    end
  end

  assign accept = (st_q == ST_IDLE) && (q_q == Q1) && start_in &&
                  (instr_word_in[OP_HI:OP_LO] == FIRST_OP);

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (accept) begin
            st_q <= ST_SRC;
          end
        end
        ST_SRC: begin
          if (q_q == Q4) begin
            st_q <= ST_DST; // RULE7
          end
        end
        ST_DST: begin
          if (q_q == Q4) begin
            st_q <= ST_IDLE; // RULE7
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Offsets come from the low bits of each word
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      zs_q <= OFS_ZERO;
      zd_q <= OFS_ZERO;
    end else begin
      if (accept) begin
        zs_q <= instr_word_in[OFS_W-1:0]; // RULE1
      end
      if ((st_q == ST_DST) && (q_q == Q1)) begin
        zd_q <= instr_word_in[OFS_W-1:0]; // RULE1
      end
    end
  end

  // Pointer sampled in Q2 of each cycle; sum wraps at 12 bits
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      src_addr_q <= ADDR_ZERO;
      dst_addr_q <= ADDR_ZERO;
    end else begin
      if ((st_q == ST_SRC) && (q_q == Q2)) begin
        src_addr_q <= ADDR_W'(sp_in + {5'h00, zs_q}); // RULE1 RULE3
      end
      if ((st_q == ST_DST) && (q_q == Q2)) begin
        dst_addr_q <= ADDR_W'(sp_in + {5'h00, zd_q}); // RULE1 RULE3
      end
    end
  end

  addr_class u_src_class (
    .addr_in      (src_addr_q),
    .indirect_out (src_ind),
    .protect_out  (src_prot)
  );

  addr_class u_dst_class (
    .addr_in      (dst_addr_q),
    .indirect_out (dst_ind),
    .protect_out  (dst_prot)
  );

  // Read side: an indirect source is never touched
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      rd_q   <= 1'b0;
      data_q <= DATA_ZERO;
    end else begin
      rd_q <= (st_q == ST_SRC) && (q_q == Q3) && !src_ind; // RULE5 RULE7
      if ((st_q == ST_SRC) && (q_q == Q4)) begin
        data_q <= src_ind ? DATA_ZERO : mem_rdata_in; // RULE2 RULE5
      end
    end
  end

  // Write side: protected or indirect destination suppresses the store
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      wr_q    <= 1'b0;
      wdata_q <= DATA_ZERO;
      skip_q  <= 1'b0;
    end else begin
      wr_q <= (st_q == ST_DST) && (q_q == Q3) &&
              !dst_ind && !dst_prot; // RULE4 RULE6 RULE7
      if ((st_q == ST_DST) && (q_q == Q3)) begin
        wdata_q <= data_q; // RULE2
        skip_q  <= dst_ind || dst_prot; // RULE4 RULE6
      end
    end
  end

  // Address bus carries the source from Q4 of cycle 1 and the target from Q4 of cycle 2
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      addr_q <= ADDR_ZERO;
    end else if ((st_q == ST_SRC) && (q_q == Q3)) begin
      addr_q <= src_addr_q;
    end else if ((st_q == ST_DST) && (q_q == Q3)) begin
      addr_q <= dst_addr_q; // RULE2
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == ST_DST) && (q_q == Q4); // RULE7
    end
  end

  // No status port exists and the pointer port sp_in is input only, so neither can be disturbed
  assign mem_addr_out  = addr_q;
  assign mem_rd_out    = rd_q;
  assign mem_wr_out    = wr_q;
  assign mem_wdata_out = wdata_q;
  assign quarter_out   = q_q;
  assign busy_out      = (st_q != ST_IDLE);
  assign done_out      = done_q;
  assign skipped_out   = skip_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn);

  src_addr_sum_a: assert property ( // RULE1
    (st_q == ST_SRC && q_q == Q2) |=>
      src_addr_q == ADDR_W'($past(sp_in) + {5'h00, zs_q}))
    else $error("source address not pointer plus offset");

  dst_addr_sum_a: assert property ( // RULE3
    (st_q == ST_DST && q_q == Q2) |=>
      dst_addr_q == ADDR_W'($past(sp_in) + {5'h00, zd_q}))
    else $error("destination address not pointer plus offset");

  copy_data_a: assert property ( // RULE2
    (mem_rd_out) |-> ##4 (!mem_wr_out ||
      mem_wdata_out == $past(mem_rdata_in, 4)))
    else $error("written value differs from value read");

  write_target_a: assert property ( // RULE2
    mem_wr_out |-> (mem_addr_out == dst_addr_q && !dst_ind))
    else $error("write aimed away from destination");

  no_protected_write_a: assert property ( // RULE4
    mem_wr_out |-> !dst_prot)
    else $error("write to protected register");

  src_ind_zero_a: assert property ( // RULE5
    (st_q == ST_SRC && q_q == Q4 && src_ind) |->
      !mem_rd_out ##1 data_q == DATA_ZERO)
    else $error("indirect source not read as zero");

  dst_ind_nop_a: assert property ( // RULE6
    (st_q == ST_DST && q_q == Q3 && dst_ind) |=> !mem_wr_out ##1 skipped_out)
    else $error("indirect destination was written");

  two_cycle_move_a: assert property ( // RULE7
    accept |-> ##4 (q_q == Q1 && !mem_wr_out) ##3 (q_q == Q4) ##1 done_out)
    else $error("move did not finish in two cycles");

  strobe_phase_a: assert property ( // RULE7
    (mem_rd_out |-> st_q == ST_SRC && q_q == Q4) and
    (mem_wr_out |-> st_q == ST_DST && q_q == Q4))
    else $error("strobe outside last quarter");

  normal_copy_c: cover property (mem_rd_out ##4 mem_wr_out);
  src_indirect_c: cover property (st_q == ST_SRC && q_q == Q4 && src_ind);
  dst_skip_c: cover property (done_out && skipped_out);
  back_to_back_c: cover property (done_out ##0 accept);
endmodule
`default_nettype wire

/* logic/pair_move_pkg.sv */
package pair_move_pkg;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 8;
  localparam int          OFS_W       = 7;
  localparam int          WORD_W      = 16;
  localparam logic [1:0]  Q1          = 2'h0;
  localparam logic [1:0]  Q2          = 2'h1;
  localparam logic [1:0]  Q3          = 2'h2;
  localparam logic [1:0]  Q4          = 2'h3;
  localparam logic [1:0]  QTR_STEP    = 2'h1;
  localparam int          OP_HI       = 15;
  localparam int          OP_LO       = 7;
  localparam logic [8:0]  FIRST_OP    = 9'h1D7;
  localparam logic [7:0]  DATA_ZERO   = 8'h00;
  localparam logic [11:0] ADDR_ZERO   = 12'h000;
  localparam logic [6:0]  OFS_ZERO    = 7'h00;
  localparam int          IND_CHANS   = 3;
  localparam int          IND_SPAN    = 5;
  localparam logic [11:0] IND_TOP [IND_CHANS] = '{12'hFEF, 12'hFE7, 12'hFDF};
  localparam logic [11:0] IND_SPAN_W  = 12'h005;
  localparam int          PROT_CNT    = 4;
  localparam logic [11:0] PROT_ADDR [PROT_CNT] =
    '{12'hFF9, 12'hFFF, 12'hFFE, 12'hFFD};
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SRC,
    ST_DST
  } move_state_e;
endpackage
